/* shared/dpm_pkg.sv */
// constants and types shared by the page-mode dram sequencer
// assumes one 125 MHz system clock and two dram banks
package dpm_pkg;
	// clock
	localparam int CLK_PERIOD_NS = 8;
	// address field shown on the multiplexed address pins
	localparam int A_HI = 27;
	localparam int A_LO = 9;
	localparam int ADDR_W = 28;
	localparam int DATA_W = 32;
	localparam int COL_W = 9;
	// transfer size codes
	localparam logic [1:0] SIZE_LONG = 2'h0;
	localparam logic [1:0] SIZE_BYTE = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;
	localparam logic [1:0] SIZE_LINE = 2'h3;
	// bank port width codes
	localparam logic [1:0] PORT_32 = 2'h0;
	localparam logic [1:0] PORT_8 = 2'h1;
	localparam logic [1:0] PORT_16 = 2'h2;
	// bank page mode codes
	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_BURST = 2'h1;
	localparam logic [1:0] MODE_FAST = 2'h2;
	// fastest timing, in clocks
	localparam int RAS_PRE_MIN_CLK = 1;
	localparam int NEW_PAGE_CLK = 3;
	localparam int MISS_TOTAL_CLK = RAS_PRE_MIN_CLK + NEW_PAGE_CLK;
	localparam int BURST_NEXT_CLK = 2;
	// reset values
	localparam logic [3:0] RST_CAS_N = 4'hF;
	localparam logic [1:0] RST_RAS_N = 2'h3;
	localparam logic [DATA_W-1:0] RST_DATA = 32'h0000_0000;
	// sequencer states
	typedef enum logic [5:0] {
		S_IDLE = 6'h01,
		S_PRE = 6'h02,
		S_ROW = 6'h04,
		S_HIT = 6'h08,
		S_COL = 6'h10,
		S_ACK = 6'h20
	} dpm_state_t;
endpackage

/* hw/dpm_wait_cnt.sv */
// down counter for precharge and column wait states
// assumes load and count requests come from the sequencer clock domain
`timescale 1ns/1ps
module dpm_wait_cnt #(
	parameter int W = 3
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// control
	input wire logic load_i,
	input wire logic [W-1:0] val_i,
	// status
	output logic zero_o
);
	logic [W-1:0] cnt_r;

	// load wins, otherwise count toward zero
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_r <= '0;
		end else if (load_i) begin
			cnt_r <= val_i;
		end else if (cnt_r != '0) begin
			cnt_r <= cnt_r - W'(1);
		end
	end

	assign zero_o = (cnt_r == '0);
endmodule

/* hw/dpm_page_track.sv */
// open-page flag and open row for one dram bank
// assumes open and close never arrive in the same cycle
`timescale 1ns/1ps
module dpm_page_track #(
	parameter int ROW_W = 19
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// page control
	input wire logic open_i,
	input wire logic close_i,
	input wire logic [ROW_W-1:0] row_i,
	// compare
	input wire logic [ROW_W-1:0] cmp_i,
	output logic open_o,
	output logic hit_o
);
	logic [ROW_W-1:0] row_r;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			open_o <= 1'b0;
			row_r <= '0;
		end else if (close_i) begin
			open_o <= 1'b0;
		end else if (open_i) begin
			open_o <= 1'b1;
			row_r <= row_i;
		end
	end

	assign hit_o = open_o && (row_r == cmp_i);
endmodule

/* hw/dpm_dram_page_ctrl.sv */
// page-mode dram sequencer: page miss, bus arbitration, burst page mode
// assumes synchronous inputs and a request port held until taken
//
// Contract
// - page miss waits for row precharge
// - other bank starts without precharge delay
// - fastest miss: one precharge plus three
// - miss writes time like miss reads
// - first cycle: row, write flag, size, start
// - row strobe, column switch, column strobes
// - byte to 8-bit port: lane zero
// - ack one cycle before data capture
// - fast page end keeps row strobe
// - miss closes row one cycle later
// - row strobe only after precharge met
// - lost mastership closes open page
// - grant lost mid dram: finish first
// - grant lost mid non-dram: precharge now
// - idle grant loss: release bus, close
// - locked bus keeps row and driven
// - alternate master uses burst page
// - burst page closes row after burst
// - non-burst uses normal closing timing
// - burst three then two clocks
// - timing inputs lengthen accesses
// - read and write strobes identical; page-hit writes add S_COL, page-hit reads skip it
// - write data from cycle after start
`timescale 1ns/1ps
module dpm_dram_page_ctrl #(
	parameter int BANK_BIT = 27,
	parameter int WAIT_W = 2
) (
	// clock and reset
	input wire logic SYS_CLK_I,
	input wire logic RSTN_I,
	// request port
	input wire logic REQ_VALID_I,
	output logic REQ_READY_O,
	input wire logic [dpm_pkg::ADDR_W-1:0] REQ_ADDR_I,
	input wire logic REQ_WRITE_I,
	input wire logic [1:0] REQ_SIZE_I,
	input wire logic REQ_ALT_I,
	input wire logic [dpm_pkg::DATA_W-1:0] REQ_WDATA_I,
	output logic ACK_O,
	output logic [dpm_pkg::DATA_W-1:0] RDATA_O,
	output logic RDATA_VALID_O,
	// configuration
	input wire logic [3:0] BANK_MODE_I,
	input wire logic [3:0] BANK_PORT_I,
	input wire logic [WAIT_W-1:0] RAS_PRE_WAIT_I,
	input wire logic [WAIT_W-1:0] CAS_WAIT_I,
	input wire logic BUS_LOCK_BIT_I,
	// arbitration
	input wire logic BUS_GRANT_N_I,
	input wire logic NONDRAM_BUSY_I,
	output logic BUS_DRIVEN_N_O,
	output logic BUS_OE_O,
	// dram pins
	output logic TRANSFER_START_N_O,
	output logic DRAM_WRITE_N_O,
	output logic [1:0] TRANSFER_SIZE_O,
	output logic [dpm_pkg::A_HI-dpm_pkg::A_LO:0] ADDR_O,
	output logic [1:0] RAS_N_O,
	output logic [3:0] CAS_N_O,
	input wire logic [dpm_pkg::DATA_W-1:0] DATA_I,
	output logic [dpm_pkg::DATA_W-1:0] DATA_O,
	output logic DATA_OE_O
);
	import dpm_pkg::*;
	localparam int ROW_W = A_HI - A_LO + 1;

	function automatic logic [2:0] op_lg(input logic [1:0] s);
		case (s)
			SIZE_BYTE: op_lg = 3'h0;
			SIZE_WORD: op_lg = 3'h1;
			SIZE_LINE: op_lg = 3'h4;
			default: op_lg = 3'h2;
		endcase
	endfunction

	function automatic logic [2:0] pt_lg(input logic [1:0] p);
		case (p)
			PORT_8: pt_lg = 3'h0;
			PORT_16: pt_lg = 3'h1;
			default: pt_lg = 3'h2;
		endcase
	endfunction

	// byte lanes: bit i drives the strobe of byte lane i from the top
	function automatic logic [3:0] lanes(input logic [1:0] p,
			input logic [1:0] s, input logic [1:0] a, input logic bst);
		logic [3:0] full;
		full = (p == PORT_8) ? 4'h1 : (p == PORT_16) ? 4'h3 : 4'hF;
		if (bst || op_lg(s) >= pt_lg(p)) begin
			lanes = full;
		end else if (s == SIZE_BYTE) begin
			lanes = 4'h1 << (a & full[3:2] | a & {1'b0, full[1]});
		end else begin
			lanes = a[1] ? 4'hC : 4'h3;
		end
	endfunction

	dpm_state_t state_r, state_nxt;
	logic [1:0] open_w, hit_w, open_set, close_set;
	logic cnt_zero, cnt_load;
	logic [WAIT_W-1:0] cnt_val;
	logic pend_r, pend_nxt, miss_r, have_r, have_nxt, ready_r;
	logic write_r, fast_r, norm_r, burst_r;
	logic [1:0] size_r, port_r;
	logic [4:0] beats_r;
	logic [ADDR_W-1:0] addr_r, addr_nx;
	logic [DATA_W-1:0] wlat_r, wlat_nx;
	logic accept, lose, bank_in, beat_more, dram_busy;
	logic [1:0] mode_in, port_in;
	logic [2:0] step, dif;
	logic [ROW_W-1:0] set_row;
	logic [3:0] cas_on;

	assign accept = REQ_VALID_I && ready_r;
	assign lose = BUS_GRANT_N_I && !BUS_LOCK_BIT_I;
	assign bank_in = REQ_ADDR_I[BANK_BIT];
	assign mode_in = BANK_MODE_I[2*bank_in +: 2];
	assign port_in = BANK_PORT_I[2*bank_in +: 2];
	assign step = 3'(3'h1 << pt_lg(port_r));
	assign beat_more = (state_r == S_ACK) && (beats_r != 5'h00);
	assign dif = (op_lg(REQ_SIZE_I) > pt_lg(port_in)) ?
		3'(op_lg(REQ_SIZE_I) - pt_lg(port_in)) : 3'h0;
	assign set_row = (state_r == S_IDLE) ? REQ_ADDR_I[A_HI:A_LO] :
		addr_r[A_HI:A_LO];

	genvar gb;
	generate
		for (gb = 0; gb < 2; gb++) begin : g_bank
			dpm_page_track #(.ROW_W(ROW_W)) u_track (
				.clk_i(SYS_CLK_I),
				.rstn_i(RSTN_I),
				.open_i(open_set[gb]),
				.close_i(close_set[gb]),
				.row_i(set_row),
				.cmp_i(REQ_ADDR_I[A_HI:A_LO]),
				.open_o(open_w[gb]),
				.hit_o(hit_w[gb])
			);
		end
	endgenerate

	dpm_wait_cnt #(.W(WAIT_W)) u_wait (
		.clk_i(SYS_CLK_I),
		.rstn_i(RSTN_I),
		.load_i(cnt_load),
		.val_i(cnt_val),
		.zero_o(cnt_zero)
	);

	// sequencer next state
	always_comb begin
		state_nxt = state_r;
		open_set = 2'h0;
		close_set = 2'h0;
		cnt_load = 1'b0;
		cnt_val = '0;
		pend_nxt = pend_r;
		case (state_r)
			S_IDLE: begin
				if (accept) begin
					if (open_w[bank_in] && hit_w[bank_in] &&
							mode_in == MODE_FAST && !REQ_ALT_I) begin
						state_nxt = S_HIT;
					end else if (open_w[bank_in]) begin
						close_set[bank_in] = 1'b1;
						state_nxt = S_PRE;
						cnt_load = 1'b1;
						cnt_val = RAS_PRE_WAIT_I;
						pend_nxt = 1'b1;
					end else begin
						open_set[bank_in] = 1'b1;
						state_nxt = S_ROW;
					end
				end else if (lose && open_w != 2'h0) begin
					close_set = 2'h3;
					state_nxt = S_PRE;
					cnt_load = 1'b1;
					cnt_val = RAS_PRE_WAIT_I;
					pend_nxt = 1'b0;
				end
			end
			S_PRE: begin
				if (cnt_zero) begin
					pend_nxt = 1'b0;
					if (pend_r) begin
						open_set[addr_r[BANK_BIT]] = 1'b1;
						state_nxt = S_ROW;
					end else begin
						state_nxt = S_IDLE;
					end
				end
			end
			S_ROW: begin
				state_nxt = S_COL;
				cnt_load = 1'b1;
				cnt_val = CAS_WAIT_I;
			end
			S_HIT: begin
				if (write_r) begin
					state_nxt = S_COL;
					cnt_load = 1'b1;
					cnt_val = CAS_WAIT_I;
				end else begin
					state_nxt = S_ACK;
				end
			end
			S_COL: begin
				if (cnt_zero) begin
					state_nxt = S_ACK;
				end
			end
			S_ACK: begin
				cnt_load = 1'b1;
				if (beat_more && !norm_r) begin
					state_nxt = S_COL;
					cnt_val = CAS_WAIT_I;
				end else if (!beat_more && fast_r && !lose) begin
					state_nxt = S_IDLE;
					cnt_load = 1'b0;
				end else begin
					close_set[addr_r[BANK_BIT]] = 1'b1;
					state_nxt = S_PRE;
					cnt_val = RAS_PRE_WAIT_I;
					pend_nxt = beat_more;
				end
			end
			default: begin
				state_nxt = S_IDLE;
			end
		endcase
	end

	// state and pending flags
	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			state_r <= S_IDLE;
			pend_r <= 1'b0;
			miss_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			pend_r <= pend_nxt;
			if (state_r == S_IDLE && accept) begin
				miss_r <= (state_nxt == S_PRE);
			end
		end
	end

	// address and write data for the current beat
	always_comb begin
		addr_nx = addr_r;
		wlat_nx = wlat_r;
		if (state_r == S_IDLE) begin
			addr_nx = REQ_ADDR_I;
			wlat_nx = REQ_WDATA_I << ((REQ_SIZE_I == SIZE_BYTE) ? 24 :
				(REQ_SIZE_I == SIZE_WORD) ? 16 : 0);
			if (dif == 3'h0) begin
				wlat_nx = wlat_nx >> (8 * (REQ_ADDR_I[1:0] &
					2'(3'h3 >> (3'h2 - pt_lg(port_in)))));
			end
		end else if (beat_more) begin
			addr_nx = addr_r + ADDR_W'(step);
			if (2'(addr_r[1:0] + step[1:0]) == 2'h0) begin
				wlat_nx = REQ_WDATA_I;
			end else begin
				wlat_nx = wlat_r << (8 * step);
			end
		end
	end

	// latched request attributes
	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			addr_r <= '0;
			wlat_r <= RST_DATA;
			write_r <= 1'b0;
			size_r <= SIZE_LONG;
			port_r <= PORT_32;
			fast_r <= 1'b0;
			norm_r <= 1'b0;
			burst_r <= 1'b0;
			beats_r <= 5'h00;
		end else begin
			addr_r <= addr_nx;
			wlat_r <= wlat_nx;
			if (state_r == S_IDLE && accept) begin
				write_r <= REQ_WRITE_I;
				size_r <= REQ_SIZE_I;
				port_r <= port_in;
				fast_r <= (mode_in == MODE_FAST) && !REQ_ALT_I;
				norm_r <= (mode_in == MODE_NORMAL);
				burst_r <= (dif != 3'h0);
				beats_r <= 5'((5'h01 << dif) - 5'h01);
			end else if (beat_more) begin
				beats_r <= beats_r - 5'h01;
			end
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			TRANSFER_START_N_O <= 1'b1;
			ADDR_O <= '0;
			DRAM_WRITE_N_O <= 1'b1;
			TRANSFER_SIZE_O <= SIZE_LONG;
		end else begin
			TRANSFER_START_N_O <= !(state_nxt == S_ROW ||
				state_nxt == S_HIT) || (state_r == S_ROW);
			if (state_nxt == S_ROW && state_r != S_ROW) begin
				ADDR_O <= addr_nx[A_HI:A_LO];
				DRAM_WRITE_N_O <= (state_r == S_IDLE) ?
					!REQ_WRITE_I : !write_r;
				TRANSFER_SIZE_O <= (state_r == S_IDLE) ?
					REQ_SIZE_I : size_r;
			end else if (state_nxt == S_HIT ||
					(state_nxt == S_COL && state_r != S_COL)) begin
				ADDR_O <= ROW_W'(addr_nx[COL_W-1:0]);
				if (state_nxt == S_HIT) begin
					DRAM_WRITE_N_O <= !REQ_WRITE_I;
					TRANSFER_SIZE_O <= REQ_SIZE_I;
				end
			end
		end
	end

	// write data from cycle after start
	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			DATA_O <= RST_DATA;
			DATA_OE_O <= 1'b0;
		end else begin
			DATA_O <= wlat_nx;
			DATA_OE_O <= write_r && (state_nxt == S_COL ||
				state_nxt == S_ACK);
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			ACK_O <= 1'b0;
			RDATA_O <= RST_DATA;
			RDATA_VALID_O <= 1'b0;
		end else begin
			ACK_O <= (state_nxt == S_ACK);
			RDATA_VALID_O <= (state_r == S_ACK) && !write_r;
			if (state_r == S_ACK && !write_r) begin
				RDATA_O <= DATA_I;
			end
		end
	end

	// strobe lanes per port and size
	assign cas_on = lanes(port_r, size_r, addr_r[1:0], burst_r);

	// row and column strobes on falling edge
	always_ff @(negedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			RAS_N_O <= RST_RAS_N;
			CAS_N_O <= RST_CAS_N;
		end else begin
			RAS_N_O <= ~open_w;
			CAS_N_O <= (state_r == S_COL || state_r == S_ACK ||
				(state_r == S_HIT && !write_r)) ? ~cas_on : RST_CAS_N;
		end
	end

	assign dram_busy = (state_nxt != S_IDLE) &&
		!(state_nxt == S_PRE && !pend_nxt);
	assign have_nxt = !BUS_GRANT_N_I || (have_r && (BUS_LOCK_BIT_I ||
		dram_busy || NONDRAM_BUSY_I));

	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			have_r <= 1'b0;
			BUS_DRIVEN_N_O <= 1'b1;
			BUS_OE_O <= 1'b0;
			REQ_READY_O <= 1'b0;
			ready_r <= 1'b0;
		end else begin
			have_r <= have_nxt;
			BUS_DRIVEN_N_O <= !have_nxt;
			BUS_OE_O <= have_nxt;
			REQ_READY_O <= (state_nxt == S_IDLE) && !lose;
			ready_r <= (state_nxt == S_IDLE) && !lose;
		end
	end

	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (!RSTN_I);

	miss_pre_a: assert property (state_r == S_ROW && miss_r &&
		$past(state_r) != S_ROW |-> $past(state_r) == S_PRE)
		else $error("miss started without precharge");
	other_bank_a: assert property (state_r == S_IDLE && accept &&
		!open_w[bank_in] |=> state_r == S_ROW &&
		!TRANSFER_START_N_O)
		else $error("closed bank access delayed");
	miss_fast_a: assert property (state_r == S_IDLE && accept &&
		state_nxt == S_PRE && RAS_PRE_WAIT_I == 2'h0 |=>
		state_r == S_PRE ##1 state_r == S_ROW)
		else $error("miss precharge not one cycle");
	new_page_a: assert property (state_r == S_ROW &&
		CAS_WAIT_I == 2'h0 |=> state_r == S_COL ##1
		(state_r == S_ACK && ACK_O) ##1 !ACK_O)
		else $error("new page access not three cycles");
	start_pulse_a: assert property (!TRANSFER_START_N_O |=>
		TRANSFER_START_N_O && !RAS_N_O[addr_r[BANK_BIT]])
		else $error("start not one cycle or row strobe late");
	lane8_a: assert property (port_r == PORT_8 && state_r == S_ACK |->
		CAS_N_O == 4'hE)
		else $error("8-bit port strobe lanes wrong");
	read_cap_a: assert property (ACK_O && !write_r |=>
		RDATA_VALID_O && RDATA_O == $past(DATA_I))
		else $error("read data not captured after ack");
	page_keep_a: assert property (state_r == S_ACK && !beat_more &&
		fast_r && !lose |=> ##1 !RAS_N_O[addr_r[BANK_BIT]])
		else $error("fast page row strobe dropped");
	burst_close_a: assert property (state_r == S_ACK && !beat_more &&
		!fast_r |=> ##1 RAS_N_O[addr_r[BANK_BIT]])
		else $error("burst page row left open");
	idle_lose_a: assert property (state_r == S_IDLE && !accept &&
		lose && !NONDRAM_BUSY_I && open_w != 2'h0 |=>
		BUS_DRIVEN_N_O && !BUS_OE_O ##1 RAS_N_O == 2'h3)
		else $error("idle grant loss not handled");
	lock_hold_a: assert property (BUS_LOCK_BIT_I && !BUS_DRIVEN_N_O |=>
		!BUS_DRIVEN_N_O)
		else $error("locked bus released");
	write_data_a: assert property (!TRANSFER_START_N_O && write_r &&
		state_r == S_ROW |=> DATA_OE_O)
		else $error("write data not driven after start");

	miss_c: cover property (state_r == S_PRE && pend_r ##1
		state_r == S_ROW);
	burst_c: cover property (beat_more && !norm_r ##1 state_r == S_COL);
	lock_c: cover property (BUS_LOCK_BIT_I && BUS_GRANT_N_I &&
		!BUS_DRIVEN_N_O && open_w != 2'h0);
	nondram_c: cover property (lose && NONDRAM_BUSY_I &&
		state_r == S_PRE);
endmodule

/* verification/dpm_dram_model.sv */
// dram bank model: row and column latched on strobe falls
// assumes strobes and address from the page-mode sequencer
`timescale 1ns/1ps
module dpm_dram_model (
	// dram pins
	input wire logic [1:0] ras_n_i,
	input wire logic [3:0] cas_n_i,
	input wire logic [18:0] addr_i,
	input wire logic write_n_i,
	input wire logic [31:0] data_i,
	output logic [31:0] data_o,
	// last written word
	output logic [31:0] wr_o
);
	logic [18:0] row_r = '0;
	logic [18:0] col_r = '0;
	logic drive_r = 1'b0;
	logic [31:0] last_r = '0;
	logic [31:0] pat;
	initial wr_o = '0;
	assign pat = {col_r[7:0], row_r[7:0], col_r[7:0], row_r[7:0]};
	// released bus shows the inverse of the last word
	assign data_o = drive_r ? pat : ~last_r;
	always @(negedge ras_n_i[0] or negedge ras_n_i[1]) begin
		row_r = addr_i;
	end
	always @(cas_n_i) begin
		if (cas_n_i == 4'hF) begin
			if (drive_r) last_r = pat;
			drive_r = 1'b0;
		end else begin
			col_r = addr_i;
			drive_r = write_n_i;
			if (!write_n_i) wr_o = data_i;
		end
	end
endmodule

/* verification/dpm_dram_page_ctrl_test.sv */
// self-checking bench for the page-mode dram sequencer
// assumes bank 0 fast page 8-bit, bank 1 fast page 16-bit
`timescale 1ns/1ps
module dpm_dram_page_ctrl_test;
	import dpm_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b1;
	logic req_valid = 1'b0;
	logic req_ready;
	logic [ADDR_W-1:0] req_addr = '0;
	logic req_write = 1'b0;
	logic [1:0] req_size = 2'h0;
	logic req_alt = 1'b0;
	logic [DATA_W-1:0] req_wdata = '0;
	logic ack;
	logic rdata_valid;
	logic [DATA_W-1:0] rdata;
	logic [1:0] ras_wait = 2'h0;
	logic lock = 1'b0;
	logic grant_n = 1'b0;
	logic nd_busy = 1'b0;
	logic bd_n;
	logic bus_oe;
	logic ts_n;
	logic dw_n;
	logic [1:0] tsize;
	logic [A_HI-A_LO:0] addr;
	logic [1:0] ras_n;
	logic [3:0] cas_n;
	logic [DATA_W-1:0] din;
	logic [DATA_W-1:0] dout;
	logic doe;
	logic [DATA_W-1:0] wr_seen;
	logic [DATA_W-1:0] rd;
	logic [A_HI-A_LO:0] ts_addr;
	logic [A_HI-A_LO:0] col_addr;
	logic ts_dw;
	logic ras_hi;
	logic [1:0] ts_sz;
	logic [3:0] cas_lo;
	int mismatches = 0;
	int checked = 0;
	int ts_at, ack_at, last_ack, acks, doe_at;
	always #4 clk = ~clk;
	dpm_dram_page_ctrl uut (
		.SYS_CLK_I(clk), .RSTN_I(rstn),
		.REQ_VALID_I(req_valid), .REQ_READY_O(req_ready),
		.REQ_ADDR_I(req_addr), .REQ_WRITE_I(req_write),
		.REQ_SIZE_I(req_size), .REQ_ALT_I(req_alt),
		.REQ_WDATA_I(req_wdata), .ACK_O(ack), .RDATA_O(rdata),
		.RDATA_VALID_O(rdata_valid), .BANK_MODE_I(4'hA),
		.BANK_PORT_I(4'h9), .RAS_PRE_WAIT_I(ras_wait),
		.CAS_WAIT_I(2'h0), .BUS_LOCK_BIT_I(lock),
		.BUS_GRANT_N_I(grant_n), .NONDRAM_BUSY_I(nd_busy),
		.BUS_DRIVEN_N_O(bd_n), .BUS_OE_O(bus_oe),
		.TRANSFER_START_N_O(ts_n), .DRAM_WRITE_N_O(dw_n),
		.TRANSFER_SIZE_O(tsize), .ADDR_O(addr), .RAS_N_O(ras_n),
		.CAS_N_O(cas_n), .DATA_I(din), .DATA_O(dout), .DATA_OE_O(doe)
	);
	dpm_dram_model dram (
		.ras_n_i(ras_n), .cas_n_i(cas_n), .addr_i(addr),
		.write_n_i(dw_n), .data_i(dout), .data_o(din), .wr_o(wr_seen)
	);
	task automatic finish_test();
		$display("mismatches %0d checked %0d", mismatches, checked);
		if (mismatches == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic access(input logic [27:0] a, input logic w,
		input logic [1:0] s, input logic alt);
		int n;
		ts_at = 0;
		ack_at = 0;
		last_ack = 0;
		acks = 0;
		doe_at = 0;
		ras_hi = 1'b0;
		cas_lo = 4'h0;
		req_addr <= a;
		req_write <= w;
		req_size <= s;
		req_alt <= alt;
		req_wdata <= {24'h00_0000, a[7:0] ^ 8'h3C};
		req_valid <= 1'b1;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (req_ready !== 1'b1 && n < 50);
		if (n >= 50) begin
			chk("request taken", 1, 0);
			finish_test();
		end
		@(posedge clk);
		req_valid <= 1'b0;
		for (n = 1; n < 60; n++) begin
			#1;
			if (ts_n === 1'b0 && ts_at == 0) begin
				ts_at = n;
				ts_addr = addr;
				ts_dw = dw_n;
				ts_sz = tsize;
			end
			if (ts_at != 0 && n == ts_at + 1) col_addr = addr;
			if (doe === 1'b1 && doe_at == 0) doe_at = n;
			if (rdata_valid === 1'b1) rd = rdata;
			if (ack === 1'b1) begin
				acks++;
				last_ack = n;
				if (ack_at == 0) ack_at = n;
			end else if (acks > 0 && req_ready === 1'b1) begin
				break;
			end
			@(negedge clk);
			#1;
			if (ras_n[a[27]] !== 1'b0) ras_hi = 1'b1;
			cas_lo = cas_lo | ~cas_n;
			@(posedge clk);
		end
		if (n >= 60) begin
			chk("access completion", 1, 0);
			finish_test();
		end
	endtask
	task automatic run(input logic [27:0] a, input logic w,
		input logic [1:0] s, input logic alt, input int ets,
		input int eack, input logic [3:0] ecas);
		access(a, w, s, alt);
		chk("start cycle", ets, ts_at);
		chk("ack cycle", eack, ack_at);
		if (eack - ets == 1) chk("hit column", {23'h0, a[8:0]}, {13'h0000, ts_addr});
		else chk("row address", {13'h0000, a[27:9]}, {13'h0000, ts_addr});
		chk("column address", {23'h00_0000, a[8:0]}, {13'h0000, col_addr});
		chk("write flag", {31'h0, !w}, {31'h0, ts_dw});
		chk("size code", {30'h0, s}, {30'h0, ts_sz});
		chk("byte lanes", {28'h0, ecas}, {28'h0, cas_lo});
		if (w) chk("write data start", ts_at + 1, doe_at);
		else chk("read byte", {24'h0, a[7:0]}, {24'h0, rd[31:24]});
	endtask
	initial begin
		rstn <= 1'b0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		run(28'h00002A5, 0, SIZE_BYTE, 0, 1, 3, 4'h1);
		chk("page kept", 0, ras_n[0]);
		@(posedge clk);
		run(28'h000043C, 0, SIZE_BYTE, 0, 2, 4, 4'h1);
		chk("row precharged", 1, ras_hi);
		@(posedge clk);
		run(28'h000065A, 1, SIZE_BYTE, 0, 2, 4, 4'h1);
		chk("byte lane data", 8'h66, wr_seen[31:24]);
		@(posedge clk);
		run(28'h8000408, 1, SIZE_LONG, 1, 1, 3, 4'h3);
		chk("burst beats", 2, acks);
		chk("beat spacing", 2, last_ack - ack_at);
		chk("burst closed", 1, ras_n[1]);
		@(posedge clk);
		run(28'h80006A4, 0, SIZE_WORD, 1, 1, 3, 4'h3);
		chk("single closed", 1, ras_n[1]);
		@(posedge clk);
		run(28'h8000A20, 0, SIZE_WORD, 0, 1, 3, 4'h3);
		chk("other page open", 0, ras_n[0]);
		@(posedge clk);
		ras_wait <= 2'h1;
		@(posedge clk);
		run(28'h00008C3, 0, SIZE_BYTE, 0, 3, 5, 4'h1);
		@(posedge clk);
		ras_wait <= 2'h0;
		run(28'h00008E1, 0, SIZE_BYTE, 0, 1, 2, 4'h1);
		@(posedge clk);
		lock <= 1'b1;
		@(posedge clk);
		grant_n <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk("locked driven", 0, bd_n);
		chk("locked page", 0, ras_n[0]);
		@(posedge clk);
		grant_n <= 1'b0;
		lock <= 1'b0;
		repeat (2) @(posedge clk);
		grant_n <= 1'b1;
		@(posedge clk);
		#1;
		chk("idle driven", 1, bd_n);
		chk("idle enable", 0, bus_oe);
		@(negedge clk);
		#1;
		chk("idle page", 1, ras_n[0]);
		@(posedge clk);
		grant_n <= 1'b0;
		run(28'h00002A5, 0, SIZE_BYTE, 0, 1, 3, 4'h1);
		@(posedge clk);
		nd_busy <= 1'b1;
		grant_n <= 1'b1;
		@(posedge clk);
		@(negedge clk);
		#1;
		chk("busy page", 1, ras_n[0]);
		chk("busy driven", 0, bd_n);
		@(posedge clk);
		nd_busy <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk("busy release", 1, bd_n);
		finish_test();
	end
endmodule
